// ### core/port_defs.svh
`ifndef PORT_DEFS_SVH
`define PORT_DEFS_SVH

// Register byte addresses
`define ADDR_BYTE_DATA    8'h08
`define ADDR_CTL_DATA     8'h09
`define ADDR_BYTE_DIR     8'h88
`define ADDR_CTL_DIR      8'h89
`define ADDR_ANALOG       8'h9F

// Reset values
`define BYTE_DIR_RST      8'hFF
`define CTL_DIR_RST       3'h7
`define ANALOG_RST        8'h00
`define ZERO8             8'h00
`define ZERO3             3'h0

// Field positions of the direction and status register
`define ST_IBF            7
`define ST_OBF            6
`define ST_INPUT_OVERRUN_FLAG           5
`define ST_PSP            4

// Writable bits of the analog configuration register
`define ANALOG_WMASK      8'h8F
// Analog pin select code that makes all control pins digital
`define CTL_DIGITAL_CFG   4'hF

// Control pin positions
`define PIN_SEL           2
`define PIN_WR            1
`define PIN_RD            0

// Host phase length in clock cycles, covers the device input filter
`define HOST_PHASE_CYCLES 4'h8
`define CNT_ONE           4'h1
`define CNT_ZERO          4'h0

`endif

// ### core/port_pkg.sv
package port_pkg;

    // Device end state
    typedef struct packed {
        logic [7:0] byte_out;   // Byte port output latch
        logic [7:0] byte_dir;   // Byte port direction, 1 = input
        logic [7:0] in_latch;   // Slave bus input latch
        logic [2:0] ctl_out;    // Control port output latch
        logic [2:0] ctl_dir;    // Control port direction, 1 = input
        logic       psp_mode;   // Slave bus port select
        logic       input_full_flag;        // Input full flag
        logic       output_full_flag;        // Output full flag
        logic       input_overrun_flag;       // Input overrun flag
        logic [7:0] analog_cfg; // Analog configuration
        logic [7:0] rdata;      // Registered read data
        logic [7:0] b_s1;       // Byte pin sync stage 1
        logic [7:0] b_s2;       // Byte pin sync stage 2
        logic [7:0] b_s3;       // Byte pin sync stage 3
        logic [7:0] b_f;        // Byte pin filtered level
        logic [2:0] c_s1;       // Control pin sync stage 1
        logic [2:0] c_s2;       // Control pin sync stage 2
        logic [2:0] c_s3;       // Control pin sync stage 3
        logic [2:0] c_f;        // Control pin filtered level
        logic       wr_act;     // External write in progress
        logic       rd_act;     // External read in progress
    } dev_state_s;

    // Host sequencer states
    typedef enum logic [4:0] {
        H_IDLE   = 5'b00001,
        H_SETUP  = 5'b00010,
        H_STROBE = 5'b00100,
        H_HOLD   = 5'b01000,
        H_DONE   = 5'b10000
    } host_state_e;

    // Host end state
    typedef struct packed {
        host_state_e state;     // Sequencer state
        logic        is_read;   // Current access is a read
        logic [7:0]  data;      // Byte to write
        logic [3:0]  cnt;       // Phase cycle counter
        logic [7:0]  rd_data;   // Byte read back
        logic        rd_valid;  // Read result pulse
    } host_state_s;

endpackage

// ### core/port_link.sv
`timescale 1ns/10ps
interface port_link;
    logic [7:0] dev_byte_o;   // Device byte pin drive value
    logic [7:0] dev_byte_oe;  // Device byte pin enable
    logic [2:0] dev_ctl_o;    // Device control pin drive value
    logic [2:0] dev_ctl_oe;   // Device control pin enable
    logic [7:0] ext_byte_o;   // Processor byte pin drive value
    logic [7:0] ext_byte_oe;  // Processor byte pin enable
    logic [2:0] ext_ctl_o;    // Processor control pin drive value
    logic [2:0] ext_ctl_oe;   // Processor control pin enable
    logic [7:0] byte_level;   // Resolved byte wire level
    logic [2:0] ctl_level;    // Resolved control wire level

    // Wire levels, device wins a clash, undriven wires pull high
    assign byte_level = (dev_byte_oe & dev_byte_o) | (~dev_byte_oe & ext_byte_oe & ext_byte_o)
                      | (~dev_byte_oe & ~ext_byte_oe);
    assign ctl_level  = (dev_ctl_oe & dev_ctl_o) | (~dev_ctl_oe & ext_ctl_oe & ext_ctl_o)
                      | (~dev_ctl_oe & ~ext_ctl_oe);

    modport dev (input byte_level, ctl_level, output dev_byte_o, dev_byte_oe, dev_ctl_o, dev_ctl_oe);
    modport ext (input byte_level, output ext_byte_o, ext_byte_oe, ext_ctl_o, ext_ctl_oe);
endinterface

// ### core/byte_port_dev.sv
// Behaviour
// - Eight byte pins, each with direction bit
// - Mode bit four selects slave bus port
// - Three control pins, each with direction bit
// - Software sets control pins input and digital
// - Analog control pins read back as zero
// - Direction bits drive pins even when analog
// - After reset control pins analog, read zero
// - Write strobe low while selected latches pins
// - Select low enables access, read strobe reads
// - Bit seven input full, read only, resets zero
// - Bit six output full until externally read
// - Bit five overrun, cleared by software only
// - Bits two to zero control directions, reset one
// - Bit three reads zero
// - Control data upper bits read zero
// - Read start clears output full at once
// - Input full clears on software latch read
// - Outside slave mode full flags held clear
// - Slave mode ignores byte direction register
`timescale 1ns/10ps
`include "port_defs.svh"
module byte_port_dev (
    input  wire logic       clock,  // System clock
    input  wire logic       rst_n,  // Synchronous reset, active low
    input  wire logic [7:0] addr,   // Register address
    input  wire logic [7:0] wdata,  // Write data
    input  wire logic       wr,     // Write strobe
    input  wire logic       rd,     // Read strobe
    output logic      [7:0] rdata,  // Read data, cycle after strobe
    port_link.dev           pins    // Pins toward the processor
);

    port_pkg::dev_state_s s_reg;   // Registered state
    port_pkg::dev_state_s s_next;  // Next state
    logic [7:0] b_agree;           // Byte sync stages agree
    logic [2:0] c_agree;           // Control sync stages agree
    logic       sel_ok;            // Slave mode and selected
    logic       wr_now;            // Filtered write access active
    logic       rd_now;            // Filtered read access active
    logic       digital;           // Control pins set digital
    logic [7:0] status;            // Direction and status read view

    // Next state and register access
    always_comb begin
        s_next  = s_reg;
        b_agree = ~(s_reg.b_s2 ^ s_reg.b_s3);
        c_agree = ~(s_reg.c_s2 ^ s_reg.c_s3);
        // Three stage sync, a change counts when stages two and three agree
        s_next.b_s1 = pins.byte_level;
        s_next.b_s2 = s_reg.b_s1;
        s_next.b_s3 = s_reg.b_s2;
        s_next.b_f  = (b_agree & s_reg.b_s3) | (~b_agree & s_reg.b_f);
        s_next.c_s1 = pins.ctl_level;
        s_next.c_s2 = s_reg.c_s1;
        s_next.c_s3 = s_reg.c_s2;
        s_next.c_f  = (c_agree & s_reg.c_s3) | (~c_agree & s_reg.c_f);
        // Slave bus decode from filtered control pins
        sel_ok  = s_reg.psp_mode & ~s_reg.c_f[`PIN_SEL];
        wr_now  = sel_ok & ~s_reg.c_f[`PIN_WR];
        rd_now  = sel_ok & ~s_reg.c_f[`PIN_RD];
        digital = (s_reg.analog_cfg[3:0] == `CTL_DIGITAL_CFG);
        status  = {s_reg.input_full_flag, s_reg.output_full_flag, s_reg.input_overrun_flag, s_reg.psp_mode, 1'b0, s_reg.ctl_dir};
        s_next.wr_act = wr_now;
        s_next.rd_act = rd_now;

        // Software register writes
        if (wr) begin
            case (addr)
                `ADDR_BYTE_DATA: begin
                    s_next.byte_out = wdata;
                    if (s_reg.psp_mode) begin
                        s_next.output_full_flag = 1'b1;
                    end
                end
                `ADDR_CTL_DATA: begin
                    s_next.ctl_out = wdata[2:0];
                end
                `ADDR_BYTE_DIR: begin
                    s_next.byte_dir = wdata;
                end
                `ADDR_CTL_DIR: begin
                    s_next.ctl_dir  = wdata[2:0];
                    s_next.psp_mode = wdata[`ST_PSP];
                    s_next.input_overrun_flag     = s_reg.input_overrun_flag & wdata[`ST_INPUT_OVERRUN_FLAG];
                end
                `ADDR_ANALOG: begin
                    s_next.analog_cfg = wdata & `ANALOG_WMASK;
                end
                default: begin
                    // Unmapped write is ignored
                end
            endcase
        end

        // Software register reads, data stands one cycle later
        s_next.rdata = `ZERO8;
        if (rd) begin
            case (addr)
                `ADDR_BYTE_DATA: begin
                    if (s_reg.psp_mode) begin
                        s_next.rdata = s_reg.in_latch;
                        s_next.input_full_flag   = 1'b0;
                    end else begin
                        s_next.rdata = s_reg.b_f;
                    end
                end
                `ADDR_CTL_DATA: begin
                    // Analog pins read zero, upper bits zero
                    s_next.rdata = {5'h00, s_reg.c_f & {3{digital}}};
                end
                `ADDR_BYTE_DIR: begin
                    s_next.rdata = s_reg.byte_dir;
                end
                `ADDR_CTL_DIR: begin
                    s_next.rdata = status;
                end
                `ADDR_ANALOG: begin
                    s_next.rdata = s_reg.analog_cfg;
                end
                default: begin
                    s_next.rdata = `ZERO8;
                end
            endcase
        end

        // External write: latch pins while active, flag at end
        if (wr_now) begin
            s_next.in_latch = s_reg.b_f;
            if (!s_reg.wr_act && s_reg.input_full_flag) begin
                s_next.input_overrun_flag = 1'b1;
            end
        end
        if (!wr_now && s_reg.wr_act) begin
            s_next.input_full_flag = 1'b1;
        end
        // External read start empties the output buffer, a same cycle software write wins
        if (rd_now && !s_reg.rd_act && !(wr && addr == `ADDR_BYTE_DATA)) begin
            s_next.output_full_flag = 1'b0;
        end
        // Full flags held clear outside slave mode, overrun kept
        if (!s_reg.psp_mode) begin
            s_next.input_full_flag = 1'b0;
            s_next.output_full_flag = 1'b0;
        end

        // Reset values
        if (!rst_n) begin
            s_next            = '0;
            s_next.byte_dir   = `BYTE_DIR_RST;
            s_next.ctl_dir    = `CTL_DIR_RST;
            s_next.analog_cfg = `ANALOG_RST;
            s_next.b_f        = `ZERO8;
            s_next.c_f        = `CTL_DIR_RST;
            s_next.c_s1       = `CTL_DIR_RST;
            s_next.c_s2       = `CTL_DIR_RST;
            s_next.c_s3       = `CTL_DIR_RST;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        s_reg <= s_next;
    end

    // Pin drive: slave mode drives the byte pins only during an external read, control pins follow their direction bits
    assign pins.dev_byte_o  = s_reg.byte_out;
    assign pins.dev_byte_oe = s_reg.psp_mode ? {8{s_reg.rd_act}} : ~s_reg.byte_dir;
    assign pins.dev_ctl_o   = s_reg.ctl_out;
    assign pins.dev_ctl_oe  = ~s_reg.ctl_dir;
    assign rdata            = s_reg.rdata;

endmodule

// ### core/byte_port_host.sv
`timescale 1ns/10ps
`include "port_defs.svh"
module byte_port_host (
    input  wire logic       clock,     // System clock
    input  wire logic       rst_n,     // Synchronous reset, active low
    input  wire logic       cmd_write, // Start bus write, pulse
    input  wire logic       cmd_read,  // Start bus read, pulse
    input  wire logic [7:0] cmd_data,  // Byte to write
    output logic            busy,      // Access in progress
    output logic      [7:0] rd_data,   // Byte read from device
    output logic            rd_valid,  // Read result pulse
    port_link.ext           pins       // Pins toward the device
);

    port_pkg::host_state_s h_reg;   // Registered state
    port_pkg::host_state_s h_next;  // Next state
    logic                  last;    // Last cycle of a phase

    // Sequencer: setup, strobe, hold, release
    always_comb begin
        h_next          = h_reg;
        h_next.rd_valid = 1'b0;
        last            = (h_reg.cnt == `HOST_PHASE_CYCLES - `CNT_ONE);
        h_next.cnt      = h_reg.cnt + `CNT_ONE;
        case (h_reg.state)
            port_pkg::H_IDLE: begin
                h_next.cnt = `CNT_ZERO;
                if (cmd_write || cmd_read) begin
                    h_next.state   = port_pkg::H_SETUP;
                    h_next.is_read = cmd_read & ~cmd_write;
                    h_next.data    = cmd_data;
                end
            end
            port_pkg::H_SETUP: begin
                // Select low, data set up, strobe idle high
                if (last) begin
                    h_next.state = port_pkg::H_STROBE;
                    h_next.cnt   = `CNT_ZERO;
                end
            end
            port_pkg::H_STROBE: begin
                // Strobe low while selected
                if (last) begin
                    h_next.state = port_pkg::H_HOLD;
                    h_next.cnt   = `CNT_ZERO;
                    if (h_reg.is_read) begin
                        h_next.rd_data = pins.byte_level;
                    end
                end
            end
            port_pkg::H_HOLD: begin
                // Strobe back high, select and data held
                if (last) begin
                    h_next.state = port_pkg::H_DONE;
                    h_next.cnt   = `CNT_ZERO;
                end
            end
            port_pkg::H_DONE: begin
                // Deselect and report
                h_next.state    = port_pkg::H_IDLE;
                h_next.cnt      = `CNT_ZERO;
                h_next.rd_valid = h_reg.is_read;
            end
            default: begin
                h_next.state = port_pkg::H_IDLE;
            end
        endcase
        if (!rst_n) begin
            h_next       = '0;
            h_next.state = port_pkg::H_IDLE;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        h_reg <= h_next;
    end

    // Control pins always driven, idle high
    assign pins.ext_ctl_oe = 3'h7;
    assign pins.ext_ctl_o[`PIN_SEL] = (h_reg.state == port_pkg::H_IDLE) || (h_reg.state == port_pkg::H_DONE);
    assign pins.ext_ctl_o[`PIN_WR]  = !((h_reg.state == port_pkg::H_STROBE) && !h_reg.is_read);
    assign pins.ext_ctl_o[`PIN_RD]  = !((h_reg.state == port_pkg::H_STROBE) && h_reg.is_read);
    // Data driven through setup, strobe and hold of a write
    assign pins.ext_byte_o  = h_reg.data;
    assign pins.ext_byte_oe = {8{!h_reg.is_read && (h_reg.state == port_pkg::H_SETUP
                              || h_reg.state == port_pkg::H_STROBE || h_reg.state == port_pkg::H_HOLD)}};
    assign busy     = (h_reg.state != port_pkg::H_IDLE);
    assign rd_data  = h_reg.rd_data;
    assign rd_valid = h_reg.rd_valid;

endmodule

// ### sim/byte_port_assertions.sv
`timescale 1ns/10ps
module byte_port_assertions (
    input wire logic       clock,       // System clock
    input wire logic       rst_n,       // Sync reset, active low
    input wire logic [7:0] dev_byte_oe, // Device byte enable
    input wire logic [7:0] ext_byte_o,  // Processor byte value
    input wire logic [7:0] ext_byte_oe, // Processor byte enable
    input wire logic [2:0] ext_ctl_o,   // Processor control levels
    input wire logic [2:0] ext_ctl_oe   // Processor control enable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [5:0] sel_cnt; // Cycles with select held low

    // Counts how long the select line stays low
    always_ff @(posedge clock) begin
        if (!rst_n || ext_ctl_o[2])
            sel_cnt <= 6'h00;
        else
            sel_cnt <= sel_cnt + 6'h01;
    end

    property p_ctl_driven; ext_ctl_oe == 3'h7; endproperty
    property p_one_strobe; ext_ctl_o[1:0] != 2'h0; endproperty
    property p_strobe_sel; (ext_ctl_o[1:0] != 2'h3) |-> !ext_ctl_o[2]; endproperty
    property p_setup; $fell(ext_ctl_o[2]) |-> (ext_ctl_o[1:0] == 2'h3) [*8] ##1 (ext_ctl_o[1:0] != 2'h3); endproperty
    property p_wr_len; $fell(ext_ctl_o[1]) |-> !ext_ctl_o[1] [*8] ##1 ext_ctl_o[1]; endproperty
    property p_rd_len; $fell(ext_ctl_o[0]) |-> !ext_ctl_o[0] [*8] ##1 ext_ctl_o[0]; endproperty
    property p_sel_len; $rose(ext_ctl_o[2]) |-> sel_cnt == 6'h18; endproperty
    property p_no_clash; (dev_byte_oe & ext_byte_oe) == 8'h00; endproperty
    property p_data_hold;
        (!ext_ctl_o[2] && !$past(ext_ctl_o[2])) |-> $stable(ext_byte_oe) && $stable(ext_byte_o & ext_byte_oe);
    endproperty
    property p_rd_drive; ($fell(ext_ctl_o[0]) && !ext_ctl_o[2]) |-> ##[2:7] (dev_byte_oe == 8'hFF); endproperty

    a_ctl_driven: assert property (p_ctl_driven) else $error("control pins not driven");
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
    a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without select");
    a_setup: assert property (p_setup) else $error("setup phase length wrong");
    a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");
    a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
    a_sel_len: assert property (p_sel_len) else $error("select low time wrong");
    a_no_clash: assert property (p_no_clash) else $error("byte pins driven by both");
    a_data_hold: assert property (p_data_hold) else $error("byte data moved in access");
    a_rd_drive: assert property (p_rd_drive) else $error("device did not drive read data");

    c_write: cover property ($fell(ext_ctl_o[1]));
    c_read: cover property ($fell(ext_ctl_o[0]));
    c_drive: cover property (dev_byte_oe == 8'hFF);
endmodule

// ### sim/tb_byte_port_with_slave_bus_control.sv
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb_byte_port_with_slave_bus_control;
    logic       clock;        // Bench clock
    logic       rst_n;        // Reset, active low
    logic [7:0] addr;         // Register address
    logic [7:0] wdata;        // Register write data
    logic       wr;           // Register write strobe
    logic       rd;           // Register read strobe
    logic [7:0] rdata;        // Register read data
    logic       cmd_write;    // Processor write command
    logic       cmd_read;     // Processor read command
    logic [7:0] cmd_data;     // Processor write byte
    logic       busy;         // Processor access busy
    logic [7:0] rd_data;      // Processor read byte
    logic       rd_valid;     // Processor read pulse
    int         error_cnt;    // Mismatches seen
    int         total_checks; // Comparisons made

    port_link lnk ();
    byte_port_dev byte_port_dev_i (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pins(lnk.dev));
    byte_port_host byte_port_host_i (.clock(clock), .rst_n(rst_n), .cmd_write(cmd_write), .cmd_read(cmd_read),
        .cmd_data(cmd_data), .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid), .pins(lnk.ext));
    byte_port_assertions byte_port_assertions_i (.clock(clock), .rst_n(rst_n), .dev_byte_oe(lnk.dev_byte_oe),
        .ext_byte_o(lnk.ext_byte_o), .ext_byte_oe(lnk.ext_byte_oe), .ext_ctl_o(lnk.ext_ctl_o),
        .ext_ctl_oe(lnk.ext_ctl_oe));

    // Clock at 10 MHz
    always #50 clock = ~clock;

    // Prints the counts and the verdict, then stops
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One-cycle register write
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // One-cycle register read, data checked in the following cycle
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    // Processor access through the slave bus, bounded wait for completion
    task automatic host_xfer(input logic rd_op, input logic [7:0] d);
        int n;
        @(posedge clock);
        cmd_read <= rd_op;
        cmd_write <= ~rd_op;
        cmd_data <= d;
        @(posedge clock);
        cmd_read <= 1'b0;
        cmd_write <= 1'b0;
        #1;
        n = 0;
        while (busy !== 1'b0 && n < 60) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 60) begin
            error_cnt++;
            $display("mismatch at %0t: access never finished", $time);
            report_and_stop();
        end
        `CHK(rd_valid, rd_op)
        if (rd_op) begin
            `CHK(rd_data, d)
        end
    endtask

    // Register values after reset, unmapped address reads zero
    task automatic t_reset_values;
        reg_rd(8'h89, 8'h07);
        reg_rd(8'h88, 8'hFF);
        reg_rd(8'h9F, 8'h00);
        reg_rd(8'h09, 8'h00);
        reg_rd(8'h00, 8'h00);
        $display("reset values done");
    endtask

    // General purpose byte port, strobes ignored outside slave mode
    task automatic t_gpio;
        reg_wr(8'h88, 8'h00);
        reg_wr(8'h08, 8'hA5);
        repeat (8) @(posedge clock);
        `CHK(lnk.byte_level, 8'hA5)
        reg_rd(8'h08, 8'hA5);
        reg_wr(8'h88, 8'hFF);
        repeat (8) @(posedge clock);
        reg_rd(8'h08, 8'hFF);
        host_xfer(1'b0, 8'h5A);
        reg_rd(8'h89, 8'h07);
        $display("gpio done");
    endtask

    // Control port direction, digital and analog readback
    task automatic t_ctl_port;
        reg_wr(8'h9F, 8'h0F);
        repeat (8) @(posedge clock);
        reg_rd(8'h09, 8'h07);
        reg_wr(8'h89, 8'h06);
        reg_wr(8'h09, 8'h00);
        repeat (2) @(posedge clock);
        `CHK(lnk.ctl_level, 3'h6)
        reg_wr(8'h9F, 8'h00);
        repeat (8) @(posedge clock);
        `CHK(lnk.ctl_level, 3'h6)
        reg_rd(8'h09, 8'h00);
        reg_wr(8'h89, 8'h07);
        reg_wr(8'h9F, 8'h0F);
        reg_wr(8'h89, 8'hFF);
        reg_rd(8'h89, 8'h17);
        $display("control port done");
    endtask

    // Slave writes, overrun, input latch read and software clear
    task automatic t_slave_write;
        reg_wr(8'h88, 8'h00);
        host_xfer(1'b0, 8'h3C);
        reg_rd(8'h89, 8'h97);
        host_xfer(1'b0, 8'h5A);
        reg_rd(8'h89, 8'hB7);
        reg_rd(8'h08, 8'h5A);
        reg_rd(8'h89, 8'h37);
        reg_wr(8'h89, 8'h17);
        reg_rd(8'h89, 8'h17);
        $display("slave write done");
    endtask

    // Slave read clears output full, leaving slave mode clears full flags
    task automatic t_slave_read;
        reg_wr(8'h08, 8'hC3);
        reg_rd(8'h89, 8'h57);
        host_xfer(1'b1, 8'hC3);
        reg_rd(8'h89, 8'h17);
        host_xfer(1'b0, 8'h11);
        host_xfer(1'b0, 8'h22);
        reg_wr(8'h08, 8'h44);
        reg_rd(8'h89, 8'hF7);
        reg_wr(8'h89, 8'h27);
        reg_rd(8'h89, 8'h27);
        $display("slave read done");
    endtask

    // Main sequence
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        cmd_write = 1'b0;
        cmd_read = 1'b0;
        cmd_data = 8'h00;
        error_cnt = 0;
        total_checks = 0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        t_reset_values();
        t_gpio();
        t_ctl_port();
        t_slave_write();
        t_slave_read();
        report_and_stop();
    end
endmodule
